// ### core/regulator_fault_supervisor.sv
// Fault supervisor, hiccup timer and strap decoder of a step-down regulator.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module regulator_fault_supervisor #(
  parameter int HICCUP_CYCLES = fault_sup_pkg::HICCUP_CYCLES_DEF,
  parameter int OVERVOLT_DEGLITCH = fault_sup_pkg::OVERVOLT_DEGLITCH_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic output_overvoltage_trip_i,
  input wire logic peak_current_limit_i,
  input wire logic fast_overcurrent_trip_i,
  input wire logic negative_current_limit_i,
  input wire logic bootstrap_undervoltage_i,
  input wire logic overtemp_i,
  input wire logic vin_ok_i,
  input wire logic enable_i,
  input wire logic soft_start_done_i,
  input wire logic cycle_start_i,
  input wire logic [4:0] strap_pin_limit_addr_i,
  input wire logic [4:0] strap_pin_freq_scenario_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic switch_enable_o,
  output logic high_side_off_o,
  output logic high_side_on_o,
  output logic power_good_output_o,
  output logic power_good_output_oe_o,
  output fault_sup_pkg::cfg_t config_o
);

  localparam int HIC_W = $clog2(HICCUP_CYCLES + 1);
  localparam int DEG_W = $clog2(OVERVOLT_DEGLITCH + 1);
  localparam int INIT_W = $clog2(fault_sup_pkg::INIT_CYCLES + 1);
  localparam int PULSE_W = $clog2(fault_sup_pkg::NEG_PULSE_CYCLES + 1);

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  fault_sup_pkg::state_t state;
  fault_sup_pkg::state_t next_state;
  fault_sup_pkg::cause_t cause;
  fault_sup_pkg::cause_t next_cause;
  fault_sup_pkg::cfg_t next_cfg;
  logic [INIT_W-1:0] init_cnt;
  logic [INIT_W-1:0] next_init_cnt;
  logic [HIC_W-1:0] hiccup_cnt;
  logic [HIC_W-1:0] next_hiccup_cnt;
  logic [DEG_W-1:0] deg_cnt;
  logic [DEG_W-1:0] next_deg_cnt;
  logic next_switch_enable;
  logic next_pg_oe;
  logic switching;
  logic peak_trip;
  logic neg_trip;
  logic sw_enable;
  logic next_sw_enable;
  logic [31:0] next_rdata;

  // ****************************************************************
  // Per-cycle current limiting state
  // ****************************************************************
  logic peak_seen;
  logic next_peak_seen;
  logic neg_seen;
  logic next_neg_seen;
  logic next_hs_off;
  logic [PULSE_W-1:0] pulse_cnt;
  logic [PULSE_W-1:0] next_pulse_cnt;
  logic cycle_end;

  assign switching = (state == fault_sup_pkg::ST_SOFT) || (state == fault_sup_pkg::ST_RUN);
  assign cycle_end = switching && cycle_start_i;

  // Strap decode: the comparator bank delivers one of 32 codes per pin.
  function automatic fault_sup_pkg::cfg_t decode_straps(input logic [4:0] code0, input logic [4:0] code1);
    fault_sup_pkg::cfg_t c;
    c.code_limit = code0;
    c.code_freq = code1;
    c.peak_sel = code0[4:3];
    c.peak_limit_da = fault_sup_pkg::PEAK_LIMIT_DA[code0[4:3]];
    c.neg_limit_da = 9'((18'(c.peak_limit_da) * fault_sup_pkg::NEG_RATIO_NUM) / fault_sup_pkg::NEG_RATIO_DEN);
    c.bus_addr = fault_sup_pkg::BUS_ADDR_BASE | {4'h0, code0[2:0]};
    if (code1 >= fault_sup_pkg::FREQ_CODE_2000) begin
      c.freq_khz = fault_sup_pkg::FREQ_2000;
    end else if (code1 >= fault_sup_pkg::FREQ_CODE_1200) begin
      c.freq_khz = fault_sup_pkg::FREQ_1200;
    end else if (code1 >= fault_sup_pkg::FREQ_CODE_1000) begin
      c.freq_khz = fault_sup_pkg::FREQ_1000;
    end else if (code1 >= fault_sup_pkg::FREQ_CODE_750) begin
      c.freq_khz = fault_sup_pkg::FREQ_750;
    end else if (code1 >= fault_sup_pkg::FREQ_CODE_600) begin
      c.freq_khz = fault_sup_pkg::FREQ_600;
    end else begin
      c.freq_khz = fault_sup_pkg::FREQ_500;
    end
    c.scenario = fault_sup_pkg::scenario_t'(3'(code1 % fault_sup_pkg::SCENARIO_COUNT));
    c.edge_modulation_option = (c.scenario >= fault_sup_pkg::SCN_C);
    return c;
  endfunction

  // ****************************************************************
  // Current-limit event counters
  // ****************************************************************
  event_run_counter #(
    .WIDTH(fault_sup_pkg::EVENT_CNT_W),
    .LIMIT(fault_sup_pkg::EVENT_LIMIT)
  ) u_peak_count (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(!switching),
    .cycle_end_i(cycle_end),
    .event_i(peak_seen),
    .trip_o(peak_trip)
  );

  event_run_counter #(
    .WIDTH(fault_sup_pkg::EVENT_CNT_W),
    .LIMIT(fault_sup_pkg::EVENT_LIMIT)
  ) u_neg_count (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(!switching),
    .cycle_end_i(cycle_end),
    .event_i(neg_seen),
    .trip_o(neg_trip)
  );

  // ****************************************************************
  // Startup, shutdown and hiccup sequencer
  // ****************************************************************

  // Computes the next sequencer state, the hiccup timer and the deglitch count.
  always_comb begin
    next_state = state;
    next_cause = cause;
    next_cfg = config_o;
    next_init_cnt = init_cnt;
    next_hiccup_cnt = hiccup_cnt;
    next_deg_cnt = '0;
    unique case (state)
      fault_sup_pkg::ST_INIT: begin
        if (init_cnt == INIT_W'(fault_sup_pkg::INIT_CYCLES - 1)) begin
          next_cfg = decode_straps(strap_pin_limit_addr_i, strap_pin_freq_scenario_i);
          next_state = fault_sup_pkg::ST_WAIT;
        end else begin
          next_init_cnt = init_cnt + INIT_W'(1);
        end
      end
      fault_sup_pkg::ST_WAIT: begin
        if (vin_ok_i && enable_i && sw_enable) begin
          next_state = fault_sup_pkg::ST_SOFT;
        end
      end
      fault_sup_pkg::ST_SOFT, fault_sup_pkg::ST_RUN: begin
        // Overvoltage is only watched once the soft-start ramp is over.
        if (state == fault_sup_pkg::ST_RUN && output_overvoltage_trip_i) begin
          next_deg_cnt = deg_cnt + DEG_W'(1);
        end
        next_hiccup_cnt = '0;
        if (fast_overcurrent_trip_i) begin
          next_state = fault_sup_pkg::ST_LATCHED;
          next_cause = fault_sup_pkg::CAUSE_FAST;
        end else if (!enable_i || !sw_enable) begin
          next_state = fault_sup_pkg::ST_WAIT;
        end else if (!vin_ok_i) begin
          next_state = fault_sup_pkg::ST_HICCUP;
          next_cause = fault_sup_pkg::CAUSE_VIN;
        end else if (next_deg_cnt == DEG_W'(OVERVOLT_DEGLITCH)) begin
          next_state = fault_sup_pkg::ST_HICCUP;
          next_cause = fault_sup_pkg::CAUSE_OVERVOLT;
        end else if (peak_trip) begin
          next_state = fault_sup_pkg::ST_HICCUP;
          next_cause = fault_sup_pkg::CAUSE_PEAK;
        end else if (neg_trip) begin
          next_state = fault_sup_pkg::ST_HICCUP;
          next_cause = fault_sup_pkg::CAUSE_NEG;
        end else if (bootstrap_undervoltage_i) begin
          next_state = fault_sup_pkg::ST_HICCUP;
          next_cause = fault_sup_pkg::CAUSE_BOOT;
        end else if (overtemp_i) begin
          next_state = fault_sup_pkg::ST_HICCUP;
          next_cause = fault_sup_pkg::CAUSE_TEMP;
        end else if (state == fault_sup_pkg::ST_SOFT && soft_start_done_i) begin
          next_state = fault_sup_pkg::ST_RUN;
        end
      end
      fault_sup_pkg::ST_HICCUP: begin
        // Level faults hold the timer at zero so the 20ms run after they clear.
        if (bootstrap_undervoltage_i || overtemp_i || !vin_ok_i) begin
          next_hiccup_cnt = '0;
        end else if (hiccup_cnt == HIC_W'(HICCUP_CYCLES - 1)) begin
          if (!output_overvoltage_trip_i) begin
            next_state = fault_sup_pkg::ST_WAIT;
          end
        end else begin
          next_hiccup_cnt = hiccup_cnt + HIC_W'(1);
        end
      end
      fault_sup_pkg::ST_LATCHED: begin
        next_state = fault_sup_pkg::ST_LATCHED;
      end
      default: begin
        next_state = fault_sup_pkg::ST_INIT;
      end
    endcase
    next_switch_enable = (next_state == fault_sup_pkg::ST_SOFT) || (next_state == fault_sup_pkg::ST_RUN);
    next_pg_oe = (next_state != fault_sup_pkg::ST_RUN);
  end

  // Registers the sequencer state.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= fault_sup_pkg::ST_INIT;
      cause <= fault_sup_pkg::CAUSE_NONE;
      config_o <= '0;
      init_cnt <= '0;
      hiccup_cnt <= '0;
      deg_cnt <= '0;
      switch_enable_o <= 1'b0;
      power_good_output_oe_o <= 1'b1;
      power_good_output_o <= 1'b0;
    end else begin
      state <= next_state;
      cause <= next_cause;
      config_o <= next_cfg;
      init_cnt <= next_init_cnt;
      hiccup_cnt <= next_hiccup_cnt;
      deg_cnt <= next_deg_cnt;
      switch_enable_o <= next_switch_enable;
      power_good_output_oe_o <= next_pg_oe;
      power_good_output_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Cycle-by-cycle current limiting
  // ****************************************************************

  // Tracks limit hits within the current cycle and times the forced high-side pulse.
  always_comb begin
    next_peak_seen = peak_seen | peak_current_limit_i;
    next_neg_seen = neg_seen | negative_current_limit_i;
    next_hs_off = high_side_off_o | peak_current_limit_i;
    next_pulse_cnt = pulse_cnt;
    if (pulse_cnt != '0) begin
      next_pulse_cnt = pulse_cnt - PULSE_W'(1);
    end
    // No forced pulse is started on the edge at which switching stops; a pulse still running when switching stops is cut short.
    if (negative_current_limit_i && !neg_seen && pulse_cnt == '0 && next_switch_enable) begin
      next_pulse_cnt = PULSE_W'(fault_sup_pkg::NEG_PULSE_CYCLES);
    end
    if (cycle_start_i) begin
      // A hit in the boundary cycle belongs to the new cycle.
      next_peak_seen = peak_current_limit_i;
      next_neg_seen = negative_current_limit_i;
      next_hs_off = peak_current_limit_i;
    end
    if (!switching) begin
      next_peak_seen = 1'b0;
      next_neg_seen = 1'b0;
      next_hs_off = 1'b0;
      next_pulse_cnt = '0;
    end
  end

  // Registers the limiting state and the switch overrides.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      peak_seen <= 1'b0;
      neg_seen <= 1'b0;
      high_side_off_o <= 1'b0;
      pulse_cnt <= '0;
      high_side_on_o <= 1'b0;
    end else begin
      peak_seen <= next_peak_seen;
      neg_seen <= next_neg_seen;
      high_side_off_o <= next_hs_off;
      pulse_cnt <= next_pulse_cnt;
      high_side_on_o <= (next_pulse_cnt != '0);
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************

  // Decodes writes to the control register and builds the read answer.
  always_comb begin
    next_sw_enable = sw_enable;
    next_rdata = '0;
    if (reg_wr_i && reg_addr_i == fault_sup_pkg::REG_CTRL) begin
      next_sw_enable = reg_wdata_i[fault_sup_pkg::CTRL_SW_ENABLE_BIT];
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        fault_sup_pkg::REG_CTRL: begin
          next_rdata[fault_sup_pkg::CTRL_SW_ENABLE_BIT] = sw_enable;
        end
        fault_sup_pkg::REG_STATUS: begin
          next_rdata[fault_sup_pkg::STATUS_STATE_LSB +: 3] = state;
          next_rdata[fault_sup_pkg::STATUS_CAUSE_LSB +: 3] = cause;
          next_rdata[fault_sup_pkg::STATUS_FAST_BIT] = (state == fault_sup_pkg::ST_LATCHED);
          next_rdata[fault_sup_pkg::STATUS_POWER_GOOD_OUTPUT_BIT] = !power_good_output_oe_o;
        end
        fault_sup_pkg::REG_CONFIG: begin
          next_rdata[fault_sup_pkg::CONFIG_CODE0_LSB +: 5] = config_o.code_limit;
          next_rdata[fault_sup_pkg::CONFIG_CODE1_LSB +: 5] = config_o.code_freq;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // Registers the control bit and the read data.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_enable <= fault_sup_pkg::CTRL_SW_ENABLE_RST;
      reg_rdata_o <= '0;
    end else begin
      sw_enable <= next_sw_enable;
      reg_rdata_o <= next_rdata;
    end
  end

endmodule

// ### core/fault_sup_pkg.sv
// Package with constants, types and the register map of the regulator fault supervisor.
package fault_sup_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int HICCUP_MS = 20;
  localparam int HICCUP_CYCLES_DEF = HICCUP_MS * (CLK_HZ / 1000);
  localparam int NEG_PULSE_NS = 180;
  localparam int NEG_PULSE_CYCLES = (NEG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYCLES = 16;
  localparam int OVERVOLT_DEGLITCH_DEF = 8;
  localparam int EVENT_LIMIT = 1024;
  localparam int EVENT_CNT_W = 11;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam int CTRL_SW_ENABLE_BIT = 0;
  localparam logic CTRL_SW_ENABLE_RST = 1'b1;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_CAUSE_LSB = 3;
  localparam int STATUS_FAST_BIT = 6;
  localparam int STATUS_POWER_GOOD_OUTPUT_BIT = 7;
  localparam int CONFIG_CODE0_LSB = 0;
  localparam int CONFIG_CODE1_LSB = 5;

  // ****************************************************************
  // Strap decode tables
  // ****************************************************************
  localparam logic [8:0] PEAK_LIMIT_DA [0:3] = '{9'h17c, 9'h14a, 9'h118, 9'h0e6};
  localparam logic [17:0] NEG_RATIO_NUM = 18'h0_0053;
  localparam logic [17:0] NEG_RATIO_DEN = 18'h0_0064;
  localparam logic [6:0] BUS_ADDR_BASE = 7'h30;
  localparam logic [4:0] FREQ_CODE_600 = 5'h06;
  localparam logic [4:0] FREQ_CODE_750 = 5'h0c;
  localparam logic [4:0] FREQ_CODE_1000 = 5'h12;
  localparam logic [4:0] FREQ_CODE_1200 = 5'h18;
  localparam logic [4:0] FREQ_CODE_2000 = 5'h1e;
  localparam logic [10:0] FREQ_500 = 11'h1f4;
  localparam logic [10:0] FREQ_600 = 11'h258;
  localparam logic [10:0] FREQ_750 = 11'h2ee;
  localparam logic [10:0] FREQ_1000 = 11'h3e8;
  localparam logic [10:0] FREQ_1200 = 11'h4b0;
  localparam logic [10:0] FREQ_2000 = 11'h7d0;
  localparam logic [4:0] SCENARIO_COUNT = 5'h06;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {SCN_A, SCN_B, SCN_C, SCN_D, SCN_E, SCN_F} scenario_t;
  typedef enum logic [2:0] {ST_INIT, ST_WAIT, ST_SOFT, ST_RUN, ST_HICCUP, ST_LATCHED} state_t;
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_OVERVOLT, CAUSE_PEAK, CAUSE_NEG, CAUSE_BOOT, CAUSE_TEMP, CAUSE_FAST, CAUSE_VIN
  } cause_t;

  typedef struct packed {
    logic [4:0] code_limit;
    logic [4:0] code_freq;
    logic [1:0] peak_sel;
    logic [8:0] peak_limit_da;
    logic [8:0] neg_limit_da;
    logic [6:0] bus_addr;
    logic [10:0] freq_khz;
    scenario_t scenario;
    logic edge_modulation_option;
  } cfg_t;

endpackage

// ### core/event_run_counter.sv
// Up-down counter of current-limit switching cycles with trip flag.
`timescale 1ns/1ps
module event_run_counter #(
  parameter int WIDTH = fault_sup_pkg::EVENT_CNT_W,
  parameter int LIMIT = fault_sup_pkg::EVENT_LIMIT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic cycle_end_i,
  input wire logic event_i,
  output logic trip_o
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_trip;

  // Counts up on event cycles, down toward zero otherwise, and clears when switching stops.
  always_comb begin
    next_count = count;
    if (clear_i) begin
      next_count = '0;
    end else if (cycle_end_i) begin
      if (event_i) begin
        if (count != '1) begin
          next_count = count + WIDTH'(1);
        end
      end else if (count != '0) begin
        next_count = count - WIDTH'(1);
      end
    end
    next_trip = !clear_i && (next_count > WIDTH'(LIMIT));
  end

  // Registers the count and the trip flag.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      trip_o <= 1'b0;
    end else begin
      count <= next_count;
      trip_o <= next_trip;
    end
  end

endmodule

// ### testbench/fault_sup_properties.sv
// Checker of the fault supervisor outputs against its comparator inputs.
`timescale 1ns/1ps
module fault_sup_properties #(
  parameter int HICCUP_CYCLES = 50
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic output_overvoltage_trip_i,
  input wire logic peak_current_limit_i,
  input wire logic fast_overcurrent_trip_i,
  input wire logic negative_current_limit_i,
  input wire logic vin_ok_i,
  input wire logic enable_i,
  input wire logic cycle_start_i,
  input wire logic switch_enable_o,
  input wire logic high_side_off_o,
  input wire logic high_side_on_o,
  input wire logic power_good_output_o,
  input wire logic power_good_output_oe_o
);
  logic fast_seen, next_fast_seen, hic, next_hic;
  int off_cnt, next_off_cnt;

  // Remembers a fast trip, whether the last stop was a fault and how long switching is off.
  always_comb begin
    next_fast_seen = fast_seen | (fast_overcurrent_trip_i & switch_enable_o);
    next_hic = switch_enable_o ? enable_i : hic;
    next_off_cnt = switch_enable_o ? 0 : off_cnt + 1;
  end

  // Registers the helper state.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fast_seen <= 1'b0;
      hic <= 1'b0;
      off_cnt <= 0;
    end else begin
      fast_seen <= next_fast_seen;
      hic <= next_hic;
      off_cnt <= next_off_cnt;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  pg_hold_low_a: assert property (!switch_enable_o |-> power_good_output_oe_o && !power_good_output_o)
    else $error("power good released while stopped");
  fast_stop_a: assert property (fast_overcurrent_trip_i && switch_enable_o |=> !switch_enable_o)
    else $error("fast trip did not stop switching");
  fast_latch_a: assert property (fast_seen |-> !switch_enable_o)
    else $error("switching resumed after fast trip");
  neg_width_a: assert property ($rose(high_side_on_o) |-> high_side_on_o[*4] ##1 !high_side_on_o)
    else $error("forced on pulse not four cycles");
  neg_cause_a: assert property ($rose(high_side_on_o) |-> $past(negative_current_limit_i))
    else $error("forced on pulse without negative hit");
  peak_off_a: assert property (switch_enable_o && enable_i && vin_ok_i && peak_current_limit_i && !cycle_start_i
    && !fast_overcurrent_trip_i |=> high_side_off_o)
    else $error("peak hit did not force high side off");
  ov_glitch_a: assert property ($rose(output_overvoltage_trip_i) && switch_enable_o ##1
    (output_overvoltage_trip_i && enable_i)[*5] |=> switch_enable_o)
    else $error("overvoltage tripped before deglitch");
  start_gate_a: assert property ($rose(switch_enable_o) |-> $past(enable_i) && $past(vin_ok_i))
    else $error("switching started without supply and enable");
  hiccup_wait_a: assert property ($rose(switch_enable_o) && hic |-> off_cnt >= HICCUP_CYCLES)
    else $error("restart before hiccup interval");
endmodule

bind regulator_fault_supervisor fault_sup_properties #(.HICCUP_CYCLES(HICCUP_CYCLES)) props (
  .clk_i(clk_i), .rst_i(rst_i), .output_overvoltage_trip_i(output_overvoltage_trip_i),
  .peak_current_limit_i(peak_current_limit_i), .fast_overcurrent_trip_i(fast_overcurrent_trip_i),
  .negative_current_limit_i(negative_current_limit_i), .vin_ok_i(vin_ok_i), .enable_i(enable_i),
  .cycle_start_i(cycle_start_i), .switch_enable_o(switch_enable_o), .high_side_off_o(high_side_off_o),
  .high_side_on_o(high_side_on_o), .power_good_output_o(power_good_output_o),
  .power_good_output_oe_o(power_good_output_oe_o));

// ### testbench/power_stage_model.sv
// Model of the power stage switching cycle and its current comparators.
`timescale 1ns/1ps
module power_stage_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic switching_i,
  input wire logic peak_fault_i,
  input wire logic neg_fault_i,
  output logic cycle_start_o,
  output logic peak_o,
  output logic neg_o
);
  logic [2:0] phase;

  // Eight-clock switching cycle that only runs while the stage switches.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= 3'h0;
    end else begin
      phase <= switching_i ? phase + 3'h1 : 3'h0;
    end
  end

  // No current flows while stopped; the valley is hit early and the peak late in a cycle.
  assign cycle_start_o = switching_i & (phase == 3'h0);
  assign peak_o = switching_i & peak_fault_i & (phase == 3'h4);
  assign neg_o = switching_i & neg_fault_i & (phase == 3'h1);
endmodule

// ### testbench/regulator_fault_supervisor_tb.sv
// Self-checking bench of the regulator fault supervisor.
`timescale 1ns/1ps
module regulator_fault_supervisor_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ov = 1'b0, fast = 1'b0, boot = 1'b0, temp = 1'b0, en = 1'b0, ssd = 1'b1, pf = 1'b0, nf = 1'b0;
  logic vin = 1'b1;
  logic rd_s = 1'b0, wr_s = 1'b0, rd_seen = 1'b0, cyc, pk, ng, sw, pgoe;
  logic [4:0] c0 = 5'h00, c1 = 5'h00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [15:0] p;
  logic [63:0] e;
  logic [63:0] exp_q[$];
  fault_sup_pkg::cfg_t cfg;
  int err_count = 0, checks_done = 0, ticks = 0;
  logic [4:0] c1s [13] = '{5'h00, 5'h05, 5'h06, 5'h0b, 5'h0c, 5'h11, 5'h12, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1e, 5'h1f};
  logic [10:0] fq [6] = '{11'h1f4, 11'h258, 11'h2ee, 11'h3e8, 11'h4b0, 11'h7d0};

  regulator_fault_supervisor #(.HICCUP_CYCLES(50)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .output_overvoltage_trip_i(ov), .peak_current_limit_i(pk),
    .fast_overcurrent_trip_i(fast), .negative_current_limit_i(ng), .bootstrap_undervoltage_i(boot),
    .overtemp_i(temp), .vin_ok_i(vin), .enable_i(en), .soft_start_done_i(ssd), .cycle_start_i(cyc),
    .strap_pin_limit_addr_i(c0), .strap_pin_freq_scenario_i(c1), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .switch_enable_o(sw), .high_side_off_o(),
    .high_side_on_o(), .power_good_output_o(), .power_good_output_oe_o(pgoe), .config_o(cfg));

  power_stage_model stage (.clk_i(clk_i), .rst_i(rst_i), .switching_i(sw), .peak_fault_i(pf),
    .neg_fault_i(nf), .cycle_start_o(cyc), .peak_o(pk), .neg_o(ng));

  // Clock of 50 ns period.
  always #25 clk_i = ~clk_i;

  // Compares read data with the oldest expectation and cuts a hung run short.
  always @(posedge clk_i) begin
    rd_seen <= rd_s;
    ticks++;
    if (rd_seen) begin
      chk(exp_q.pop_front(), {32'h0, rdata});
    end
    if (ticks == 40000) begin
      err_count++;
      stop_test();
    end
  end

  // ********************************
  // Tasks
  // ********************************
  task automatic chk(input logic [63:0] x, input logic [63:0] g);
    checks_done++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %0t exp=%h got=%h", $time, x, g);
    end
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back({32'h0, x});
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic power_cycle(input logic [4:0] a, input logic [4:0] b);
    c0 <= a;
    c1 <= b;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask

  task automatic wait_sw(input logic lv, input int lim);
    int n;
    n = 0;
    while (sw !== lv && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk(lv, sw);
  endtask

  task automatic count_cyc(input int n, output int k);
    k = 0;
    while (k < n && sw === 1'b1) begin
      @(posedge clk_i);
      k += int'(cyc);
    end
  endtask

  task automatic run_hits(input logic neg, input int n1, input int m, input int x);
    int c;
    // A warm-up run and a quiet run come first only when asked for, so no pin is driven twice in one step.
    if (n1 > 0) begin
      pf <= ~neg;
      nf <= neg;
      count_cyc(n1, c);
      pf <= 1'b0;
      nf <= 1'b0;
      count_cyc(m, c);
    end
    pf <= ~neg;
    nf <= neg;
    count_cyc(2000, c);
    pf <= 1'b0;
    nf <= 1'b0;
    chk(1'b1, c >= x - 1 && c <= x + 1);
  endtask

  task automatic stop_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence: strap decode, start gating, then each protection in turn.
  initial begin
    void'($urandom(32'hea99));
    for (int i = 0; i < 13; i++) begin
      power_cycle((i < 8) ? 5'(i * 4 + (i % 2) * 3) : 5'($urandom_range(31, 0)), c1s[i]);
      p = 16'h017c - 16'h0032 * c0[4:3];
      chk(p, cfg.peak_limit_da);
      chk(p * 16'h0053 / 16'h0064, cfg.neg_limit_da);
      e = {7'h30 + c0[2:0], fq[c1 / 5'h06], 3'(c1 % 5'h06), c1 % 5'h06 > 5'h01};
      chk(e, {cfg.bus_addr, cfg.freq_khz, cfg.scenario, cfg.edge_modulation_option});
      reg_read(8'h08, {22'h0, c1, c0});
      e = cfg;
      c0 <= ~c0;
      c1 <= ~c1;
      repeat (3) @(posedge clk_i);
      chk(e, cfg);
    end
    reg_read(8'h00, 32'h0000_0001);
    reg_read(8'h0c, 32'h0000_0000);
    reg_write(8'h00, 32'h0000_0000);
    ssd <= 1'b0;
    en <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(1'b0, sw);
    reg_write(8'h00, 32'h0000_0001);
    wait_sw(1'b1, 10);
    ov <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(1'b1, sw);
    ov <= 1'b0;
    ssd <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(1'b0, pgoe);
    ov <= 1'b1;
    repeat (5) @(posedge clk_i);
    ov <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(1'b1, sw);
    ov <= 1'b1;
    wait_sw(1'b0, 12);
    repeat (200) @(posedge clk_i);
    chk(1'b0, sw);
    ov <= 1'b0;
    wait_sw(1'b1, 10);
    run_hits(1'b0, 600, 300, 725);
    wait_sw(1'b1, 80);
    run_hits(1'b1, 0, 0, 1025);
    wait_sw(1'b1, 80);
    for (int k = 0; k < 3; k++) begin
      {vin, boot, temp} <= (k == 2) ? 3'h0 : ((k == 1) ? 3'h5 : 3'h6);
      wait_sw(1'b0, 3);
      repeat (100) @(posedge clk_i);
      {vin, boot, temp} <= 3'h4;
      repeat (40) @(posedge clk_i);
      chk(1'b0, sw);
      wait_sw(1'b1, 40);
    end
    en <= 1'b0;
    wait_sw(1'b0, 3);
    en <= 1'b1;
    wait_sw(1'b1, 5);
    fast <= 1'b1;
    @(posedge clk_i);
    fast <= 1'b0;
    wait_sw(1'b0, 2);
    repeat (300) @(posedge clk_i);
    chk(1'b0, sw);
    reg_read(8'h04, 32'h0000_0075);
    power_cycle(c0, c1);
    wait_sw(1'b1, 10);
    stop_test();
  end
endmodule
